// ---- sdsw_defs.svh ----
`ifndef SDSW_DEFS_SVH
`define SDSW_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SDSW_IDX_CTRL        8'h10
`define SDSW_IDX_COARSE      8'h11
`define SDSW_IDX_FINE        8'h12
`define SDSW_IDX_STATUS      8'h13
`define SDSW_IDX_FLAGS_LOW   8'h2c
`define SDSW_IDX_FLAGS_MID   8'h2d
`define SDSW_IDX_FLAGS_HIGH  8'h2e

// ****************************************************************
// Control register field positions
// ****************************************************************
`define SDSW_CTRL_INVERT     0
`define SDSW_CTRL_GLIDE_EN   1
`define SDSW_CTRL_GLIDE_FAST 2
`define SDSW_CTRL_FINE_WIN   3
`define SDSW_CTRL_SINGLE_CH  4
`define SDSW_CTRL_TAP_LSB    8
`define SDSW_CTRL_TAP_MSB    11

// ****************************************************************
// Status register field positions
// ****************************************************************
`define SDSW_STAT_APPLIED_LSB 0
`define SDSW_STAT_APPLIED_MSB 7
`define SDSW_STAT_GLIDING     8

// ****************************************************************
// Reset values
// ****************************************************************
`define SDSW_RST_CTRL        16'h0008
`define SDSW_RST_COARSE      8'h00
`define SDSW_RST_FINE        8'h00

// ****************************************************************
// Timing counts: glide window and frame length in device clock cycles, glide steps per window
// ****************************************************************
`define SDSW_GLIDE_WINDOW    256
`define SDSW_GLIDE_SLOW_STEPS 1
`define SDSW_GLIDE_FAST_STEPS 4
`define SDSW_FRAME_LEN       16

`endif

// ---- sdsw_pkg.sv ----
package sdsw_pkg;

  typedef enum logic {
    SDSW_GLIDE_IDLE,
    SDSW_GLIDE_RUN
  } sdsw_glide_state_t;

  typedef logic [7:0]  sdsw_code_t;
  typedef logic [23:0] sdsw_flags_t;

endpackage : sdsw_pkg

// ---- sdsw_glide.sv ----
`timescale 1ns/10ps
`include "sdsw_defs.svh"

module sdsw_glide #(
  parameter int WINDOW     = `SDSW_GLIDE_WINDOW,
  parameter int SLOW_STEPS = `SDSW_GLIDE_SLOW_STEPS,
  parameter int FAST_STEPS = `SDSW_GLIDE_FAST_STEPS
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               wr_stb,
  input  wire sdsw_pkg::sdsw_code_t wr_code,
  input  wire logic               glide_enable,
  input  wire logic               glide_speed_select,
  output sdsw_pkg::sdsw_code_t    applied_q,
  output logic                    gliding_q
);

  localparam int SLOW_GAP = WINDOW / SLOW_STEPS;
  localparam int FAST_GAP = WINDOW / FAST_STEPS;

  sdsw_pkg::sdsw_code_t        target_q;
  sdsw_pkg::sdsw_glide_state_t state_q;
  logic [15:0]                 tick_cnt_q;
  logic                        tick;
  logic [15:0]                 gap;

  assign gap  = glide_speed_select ? 16'(FAST_GAP - 1) : 16'(SLOW_GAP - 1);
  assign tick = (tick_cnt_q >= gap);

  // ****************************************************************
  // Step pacing, restarted by every write so a new glide starts clean
  // ****************************************************************
  // glide step rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 16'h0000;
    end else if (wr_stb || tick || state_q == sdsw_pkg::SDSW_GLIDE_IDLE) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // ****************************************************************
  // Target, applied code and glide state
  // ****************************************************************
  // write starts glide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      target_q  <= `SDSW_RST_COARSE;
      applied_q <= `SDSW_RST_COARSE;
      state_q   <= sdsw_pkg::SDSW_GLIDE_IDLE;
    end else if (wr_stb) begin
      target_q <= wr_code;
      if (glide_enable && wr_code != applied_q) begin
        state_q <= sdsw_pkg::SDSW_GLIDE_RUN;
      end else begin
        // Without glide the new code lands at once
        applied_q <= wr_code;
        state_q   <= sdsw_pkg::SDSW_GLIDE_IDLE;
      end
    end else begin
      case (state_q)
        sdsw_pkg::SDSW_GLIDE_IDLE: begin
          state_q <= sdsw_pkg::SDSW_GLIDE_IDLE;
        end
        sdsw_pkg::SDSW_GLIDE_RUN: begin
          if (tick) begin
            if (applied_q < target_q) begin
              applied_q <= applied_q + 8'h01;
            end else if (applied_q > target_q) begin
              applied_q <= applied_q - 8'h01;
            end
            if ((applied_q + 8'h01 == target_q && applied_q < target_q) ||
                (applied_q - 8'h01 == target_q && applied_q > target_q) ||
                applied_q == target_q) begin
              state_q <= sdsw_pkg::SDSW_GLIDE_IDLE;
            end
          end
        end
        default: begin
          state_q <= sdsw_pkg::SDSW_GLIDE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gliding_q <= 1'b0;
    end else begin
      gliding_q <= (state_q == sdsw_pkg::SDSW_GLIDE_RUN);
    end
  end

endmodule : sdsw_glide

// ---- sdsw_window.sv ----
`timescale 1ns/10ps
`include "sdsw_defs.svh"

module sdsw_window #(
  parameter int TAPS = 24
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [TAPS-1:0]   tap_samples,
  input  wire logic [3:0]        capture_tap_select,
  output logic      [TAPS-1:0]   capture_window_flags_q,
  output logic                   capture_event_q
);

  logic [TAPS-1:0] prev_q;
  logic [TAPS-1:0] risky;
  logic            picked_q;

  // ****************************************************************
  // Per-tap judgement: a tap next to a neighbour that disagrees sits
  // on the SYSREF edge and may violate setup or hold
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_tap
      if (g == 0 || g == TAPS - 1) begin : g_end
        assign risky[g] = 1'b1;
      end else begin : g_mid
        assign risky[g] = (tap_samples[g] != tap_samples[g-1]) ||
                          (tap_samples[g] != tap_samples[g+1]);
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q                 <= '0;
      capture_window_flags_q <= '1;
    end else begin
      prev_q <= tap_samples;
      // Only a cycle that shows an edge among the taps says where it is
      if (tap_samples != prev_q && tap_samples != '0 && tap_samples != '1) begin
        capture_window_flags_q <= risky;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      picked_q        <= 1'b0;
      capture_event_q <= 1'b0;
    end else begin
      picked_q        <= tap_samples[capture_tap_select];
      capture_event_q <= tap_samples[capture_tap_select] && !picked_q;
    end
  end

endmodule : sdsw_window

// ---- sdsw_top.sv ----
// Behaviour
// - Inversion bit delays all internal clocks by half a device clock period.
// - Coarse and fine delay codes each give 256 settings.
// - Inversion, coarse and fine settings are independent and add together.
// - Every internal clock, output bus and SYSREF capture, moves by the delay.
// - Delay settings change on the fly, no stop or reset needed.
// - With glide on, applied coarse code walks gradually to the written one.
// - Glide speed: one step or four steps per 256 device clock cycles.
// - Glide enable turns glide on; each coarse write starts a new glide.
// - Single-channel mode samples on both clock edges.
// - Detect SYSREF position within the clock cycle into window flags.
// - Each flag is one tap: 1 means risky, 0 means valid.
// - SYSREF is captured at the tap whose index the tap select holds.
// - 24 flags reported; tap select reaches only taps 0 to 15.
// - Flags 0 and 23 always read 1.
// - Fine window steps: 0 spaces taps coarsely, 1 finely.
// - Captured SYSREF resets clock dividers and frame marker generation.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "sdsw_defs.svh"

module sdsw_top #(
  parameter int TAPS      = 24,
  parameter int FRAME_LEN = `SDSW_FRAME_LEN
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [9:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic [TAPS-1:0] sysref_tap_samples,
  output logic             clock_invert_delay,
  output logic [7:0]       coarse_delay_code,
  output logic [7:0]       fine_delay_code,
  output logic             window_fine_steps,
  output logic             dual_edge_sample,
  output logic [3:0]       capture_tap_select,
  output logic             sysref_event,
  output logic             output_bus_frame_marker,
  output logic             output_bus_clock
);

  // ****************************************************************
  // Local signals
  // ****************************************************************
  logic [15:0]       ctrl_q;
  logic [7:0]        coarse_wr_q;
  logic              req;
  logic              wr_lane0;
  logic              wr_lane1;
  logic [7:0]        index;
  logic              coarse_wr_stb;
  logic [TAPS-1:0]   tap_meta_q;
  logic [TAPS-1:0]   tap_sync_q;
  logic [TAPS-1:0]   flags;
  logic              capture_event;
  logic [7:0]        applied_coarse;
  logic              gliding;
  logic [7:0]        frame_cnt_q;
  logic [31:0]       rd_data;

  // ****************************************************************
  // Wishbone classic slave decode
  // ****************************************************************
  // Word registers: the low two address bits are ignored
  assign index    = wb_adr[9:2];
  assign req      = wb_cyc && wb_stb && !wb_ack;
  assign wr_lane0 = req && wb_we && wb_sel[0];
  assign wr_lane1 = req && wb_we && wb_sel[1];

  assign coarse_wr_stb = wr_lane0 && (index == `SDSW_IDX_COARSE);

  // One wait state; every address is answered, unmapped ones read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= req;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // on-the-fly update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SDSW_RST_CTRL;
    end else if (index == `SDSW_IDX_CTRL) begin
      if (wr_lane0) begin
        ctrl_q[7:0] <= wb_dat_w[7:0];
      end
      if (wr_lane1) begin
        ctrl_q[15:8] <= wb_dat_w[15:8];
      end
    end
  end

  // ****************************************************************
  // Delay codes
  // ****************************************************************
  // coarse written code
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_wr_q <= `SDSW_RST_COARSE;
    end else if (coarse_wr_stb) begin
      coarse_wr_q <= wb_dat_w[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fine_delay_code <= `SDSW_RST_FINE;
    end else if (wr_lane0 && index == `SDSW_IDX_FINE) begin
      fine_delay_code <= wb_dat_w[7:0];
    end
  end

  sdsw_glide u_glide (
    .clk                (clk),
    .rst_n              (rst_n),
    .wr_stb             (coarse_wr_stb),
    .wr_code            (wb_dat_w[7:0]),
    .glide_enable       (ctrl_q[`SDSW_CTRL_GLIDE_EN]),
    .glide_speed_select (ctrl_q[`SDSW_CTRL_GLIDE_FAST]),
    .applied_q          (applied_coarse),
    .gliding_q          (gliding)
  );

  // ****************************************************************
  // Delay outputs to the analog clock path
  // ****************************************************************
  // half-period inversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_invert_delay <= 1'b0;
    end else begin
      clock_invert_delay <= ctrl_q[`SDSW_CTRL_INVERT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_delay_code <= `SDSW_RST_COARSE;
    end else begin
      coarse_delay_code <= applied_coarse;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_edge_sample   <= 1'b0;
      window_fine_steps  <= 1'b1;
    end else begin
      dual_edge_sample   <= ctrl_q[`SDSW_CTRL_SINGLE_CH];
      window_fine_steps  <= ctrl_q[`SDSW_CTRL_FINE_WIN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_tap_select <= 4'h0;
    end else begin
      capture_tap_select <= ctrl_q[`SDSW_CTRL_TAP_MSB:`SDSW_CTRL_TAP_LSB];
    end
  end

  // ****************************************************************
  // SYSREF tap samples arrive from the analog delay line
  // ****************************************************************
  // The taps are asynchronous to this clock, hence two stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_meta_q <= '0;
      tap_sync_q <= '0;
    end else begin
      tap_meta_q <= sysref_tap_samples;
      tap_sync_q <= tap_meta_q;
    end
  end

  sdsw_window #(
    .TAPS (TAPS)
  ) u_window (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .tap_samples            (tap_sync_q),
    .capture_tap_select     (ctrl_q[`SDSW_CTRL_TAP_MSB:`SDSW_CTRL_TAP_LSB]),
    .capture_window_flags_q (flags),
    .capture_event_q        (capture_event)
  );

  // ****************************************************************
  // Divider and frame marker, realigned by each captured SYSREF
  // ****************************************************************
  // SYSREF resets dividers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_q <= 8'h00;
    end else if (capture_event || frame_cnt_q == 8'(FRAME_LEN - 1)) begin
      frame_cnt_q <= 8'h00;
    end else begin
      frame_cnt_q <= frame_cnt_q + 8'h01;
    end
  end

  // Marker flags the last unit of a frame
  // strobe restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_bus_frame_marker <= 1'b0;
    end else if (capture_event) begin
      output_bus_frame_marker <= 1'b0;
    end else begin
      output_bus_frame_marker <= (frame_cnt_q == 8'(FRAME_LEN - 2));
    end
  end

  // The bus clock halves clk; restarting it low keeps devices in phase
  // divider restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_bus_clock <= 1'b0;
    end else if (capture_event) begin
      output_bus_clock <= 1'b0;
    end else begin
      output_bus_clock <= !output_bus_clock;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysref_event <= 1'b0;
    end else begin
      sysref_event <= capture_event;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    case (index)
      `SDSW_IDX_CTRL: begin
        rd_data[15:0] = ctrl_q;
      end
      `SDSW_IDX_COARSE: begin
        rd_data[7:0] = coarse_wr_q;
      end
      `SDSW_IDX_FINE: begin
        rd_data[7:0] = fine_delay_code;
      end
      `SDSW_IDX_STATUS: begin
        rd_data[`SDSW_STAT_APPLIED_MSB:`SDSW_STAT_APPLIED_LSB] = applied_coarse;
        rd_data[`SDSW_STAT_GLIDING] = gliding;
      end
      `SDSW_IDX_FLAGS_LOW: begin
        rd_data[7:0] = flags[7:0];
      end
      `SDSW_IDX_FLAGS_MID: begin
        rd_data[7:0] = flags[15:8];
      end
      `SDSW_IDX_FLAGS_HIGH: begin
        rd_data[7:0] = flags[23:16];
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_r <= rd_data;
    end
  end

endmodule : sdsw_top

// ---- sdsw_clk_src.sv ----
`timescale 1ns/10ps

// ****************************************************************
// Far-side clock source: SYSREF as seen at each delayed tap
// ****************************************************************
module sdsw_clk_src #(
  parameter int TAPS = 24
) (
  input  wire logic            clk,
  input  wire logic            level,
  input  wire logic [4:0]      edge_pos,
  output logic      [TAPS-1:0] taps
);
  // fixed edge position
  // With level high, taps at or past the edge read 1 and earlier ones 0; level low clears every tap
  always @(posedge clk) begin
    taps <= level ? ({TAPS{1'b1}} << edge_pos) : '0;
  end
endmodule : sdsw_clk_src

// ---- sdsw_top_sva.sv ----
`timescale 1ns/10ps
`include "sdsw_defs.svh"

module sdsw_sva #(
  parameter int TAPS      = 24,
  parameter int FRAME_LEN = 16
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            wb_cyc,
  input wire logic            wb_stb,
  input wire logic            wb_we,
  input wire logic [9:0]      wb_adr,
  input wire logic [3:0]      wb_sel,
  input wire logic [31:0]     wb_dat_w,
  input wire logic [31:0]     wb_dat_r,
  input wire logic            wb_ack,
  input wire logic [TAPS-1:0] sysref_tap_samples,
  input wire logic            clock_invert_delay,
  input wire logic [7:0]      coarse_delay_code,
  input wire logic [7:0]      fine_delay_code,
  input wire logic            window_fine_steps,
  input wire logic            dual_edge_sample,
  input wire logic [3:0]      capture_tap_select,
  input wire logic            sysref_event,
  input wire logic            output_bus_frame_marker,
  input wire logic            output_bus_clock
);
  logic       take;
  logic [7:0] idx;
  logic       glide_q;
  assign take = wb_cyc && wb_stb && !wb_ack;
  assign idx  = wb_adr[9:2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glide_q <= 1'b0;
    end else if (take && wb_we && wb_sel[0] && idx == `SDSW_IDX_CTRL) begin
      glide_q <= wb_dat_w[`SDSW_CTRL_GLIDE_EN];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_ack_next: assert property (take |=> wb_ack)
    else $error("request not acknowledged");
  chk_ctrl_apply: assert property (take && wb_we && wb_sel[0] && idx == `SDSW_IDX_CTRL |-> ##2
    clock_invert_delay == $past(wb_dat_w[0], 2) && window_fine_steps == $past(wb_dat_w[3], 2)
    && dual_edge_sample == $past(wb_dat_w[4], 2)) else $error("control bits not applied");
  chk_tap_apply: assert property (take && wb_we && wb_sel[1] && idx == `SDSW_IDX_CTRL |->
    ##2 capture_tap_select == $past(wb_dat_w[11:8], 2)) else $error("tap select not applied");
  chk_fine_apply: assert property (take && wb_we && wb_sel[0] && idx == `SDSW_IDX_FINE |->
    ##2 fine_delay_code == $past(wb_dat_w[7:0], 2)) else $error("fine code not applied");
  chk_glide_step: assert property (glide_q && $changed(coarse_delay_code) |->
    (coarse_delay_code - $past(coarse_delay_code) == 8'h01) ||
    ($past(coarse_delay_code) - coarse_delay_code == 8'h01)) else $error("glide jumped");
  chk_glide_rate: assert property (glide_q && $changed(coarse_delay_code) |=>
    $stable(coarse_delay_code)[*8]) else $error("glide steps too close");
  chk_flag_ends: assert property (take && !wb_we && idx == `SDSW_IDX_FLAGS_LOW |=>
    wb_dat_r[0] && wb_dat_r[31:8] == 24'h00_0000) else $error("low end flag clear");
  chk_flag_top: assert property (take && !wb_we && idx == `SDSW_IDX_FLAGS_HIGH |=>
    wb_dat_r[7] && wb_dat_r[31:8] == 24'h00_0000) else $error("high end flag clear");
  chk_event_pulse: assert property (sysref_event |=> !sysref_event)
    else $error("capture event too long");
  chk_frame_gap: assert property (output_bus_frame_marker |=> (!output_bus_frame_marker)[*8])
    else $error("frame markers too close");
  cov_event: cover property (sysref_event);
  cov_glide: cover property (glide_q && $changed(coarse_delay_code));
  cov_flags: cover property (take && !wb_we && idx == `SDSW_IDX_FLAGS_MID);
endmodule : sdsw_sva

bind sdsw_top sdsw_sva #(.TAPS(TAPS), .FRAME_LEN(FRAME_LEN)) u_sdsw_sva (
  .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
  .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .sysref_tap_samples(sysref_tap_samples),
  .clock_invert_delay(clock_invert_delay), .coarse_delay_code(coarse_delay_code),
  .fine_delay_code(fine_delay_code), .window_fine_steps(window_fine_steps),
  .dual_edge_sample(dual_edge_sample), .capture_tap_select(capture_tap_select),
  .sysref_event(sysref_event), .output_bus_frame_marker(output_bus_frame_marker),
  .output_bus_clock(output_bus_clock));

// ---- tb_sdsw_top.sv ----
`timescale 1ns/10ps
`include "sdsw_defs.svh"

module tb_sdsw_top;
  localparam int FL = 16;
  logic        clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack, lvl;
  logic [9:0]  wb_adr;
  logic [3:0]  wb_sel, tap_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [23:0] taps;
  logic [7:0]  coarse, fine;
  logic        inv, win_fine, dual, sref_ev, marker, bus_clk;
  int          fails, num_checks;

  sdsw_clk_src u_sdsw_clk_src (.clk(clk), .level(lvl), .edge_pos(5'h09), .taps(taps));
  sdsw_top #(.TAPS(24), .FRAME_LEN(FL)) u_sdsw_top (
    .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .sysref_tap_samples(taps), .clock_invert_delay(inv),
    .coarse_delay_code(coarse), .fine_delay_code(fine), .window_fine_steps(win_fine),
    .dual_edge_sample(dual), .capture_tap_select(tap_sel), .sysref_event(sref_ev),
    .output_bus_frame_marker(marker), .output_bus_clock(bus_clk));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************************************
  // Bus and checking tasks
  // ****************************************************************
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic we, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= {idx, 2'b00};
    wb_sel   <= sel;
    wb_dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (wb_ack !== 1'b1) begin
      fails++;
      finish_test();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic rdx(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000, 4'h0);
    chk(rd, exp);
  endtask : rdx

  task automatic see_event(input logic exp);
    logic hit;
    logic bclk_at_hit;
    hit = 1'b0;
    bclk_at_hit = 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (sref_ev === 1'b1) begin
        hit = 1'b1;
        bclk_at_hit = bus_clk;
      end
    end
    chk({31'h0, hit}, {31'h0, exp});
    // Bus clock divider restarts low together with the captured event
    if (exp) begin
      chk({31'h0, bclk_at_hit}, 32'h0000_0000);
    end
  endtask : see_event

  // Measures edges between two frame markers; waits are bounded
  task automatic frame_period;
    int n;
    n = 0;
    while (marker !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (marker !== 1'b1) begin
      fails++;
      finish_test();
    end
    @(posedge clk);
    n = 1;
    while (marker !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(n, FL);
  endtask : frame_period

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    fails = 0;
    num_checks = 0;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 10'h000;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
    lvl = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({31'h0, win_fine}, 32'h0000_0001);
    rdx(`SDSW_IDX_CTRL, 32'h0000_0008);
    rdx(`SDSW_IDX_FLAGS_LOW, 32'h0000_00ff);
    rdx(`SDSW_IDX_FLAGS_HIGH, 32'h0000_00ff);
    xfer(1'b1, `SDSW_IDX_FLAGS_LOW, 32'h0000_0000, 4'h3);
    rdx(`SDSW_IDX_FLAGS_LOW, 32'h0000_00ff);
    xfer(1'b1, 8'h3f, 32'h0000_5a5a, 4'h3);
    rdx(8'h3f, 32'h0000_0000);
    // Invert, fast bit, single channel, coarse window spacing, tap 3
    xfer(1'b1, `SDSW_IDX_CTRL, 32'h0000_0315, 4'h3);
    chk({28'h0, inv, win_fine, dual, 1'b0}, 32'h0000_000a);
    chk({28'h0, tap_sel}, 32'h0000_0003);
    xfer(1'b1, `SDSW_IDX_FINE, 32'h0000_00ff, 4'h0);
    rdx(`SDSW_IDX_FINE, 32'h0000_0000);
    xfer(1'b1, `SDSW_IDX_FINE, 32'h0000_00ff, 4'h1);
    xfer(1'b1, `SDSW_IDX_COARSE, 32'h0000_00a5, 4'h1);
    chk({15'h0, inv, coarse, fine}, 32'h0001_a5ff);
    rdx(`SDSW_IDX_STATUS, 32'h0000_00a5);
    // SYSREF edge at tap 9, capture at tap 10
    xfer(1'b1, `SDSW_IDX_CTRL, 32'h0000_0a08, 4'h3);
    lvl <= 1'b1;
    see_event(1'b1);
    frame_period();
    rdx(`SDSW_IDX_FLAGS_LOW, 32'h0000_0001);
    rdx(`SDSW_IDX_FLAGS_MID, 32'h0000_0003);
    rdx(`SDSW_IDX_FLAGS_HIGH, 32'h0000_0080);
    lvl <= 1'b0;
    xfer(1'b1, `SDSW_IDX_CTRL, 32'h0000_0408, 4'h3);
    lvl <= 1'b1;
    see_event(1'b0);
    // Slow glide down two steps
    xfer(1'b1, `SDSW_IDX_CTRL, 32'h0000_000a, 4'h3);
    chk({28'h0, tap_sel}, 32'h0000_0000);
    xfer(1'b1, `SDSW_IDX_COARSE, 32'h0000_00a3, 4'h1);
    repeat (200) @(posedge clk);
    chk(coarse, 32'h0000_00a5);
    rdx(`SDSW_IDX_STATUS, 32'h0000_01a5);
    repeat (80) @(posedge clk);
    chk(coarse, 32'h0000_00a4);
    repeat (600) @(posedge clk);
    chk(coarse, 32'h0000_00a3);
    rdx(`SDSW_IDX_STATUS, 32'h0000_00a3);
    // Fast glide up four steps
    xfer(1'b1, `SDSW_IDX_CTRL, 32'h0000_000e, 4'h3);
    xfer(1'b1, `SDSW_IDX_COARSE, 32'h0000_00a7, 4'h1);
    repeat (90) @(posedge clk);
    chk(coarse, 32'h0000_00a4);
    repeat (200) @(posedge clk);
    chk(coarse, 32'h0000_00a7);
    finish_test();
  end
endmodule : tb_sdsw_top
